/* rtl/ddrte_pkg.sv */
// constants, commands and register map of the ddr3 command timing enforcer
package ddrte_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RESET_HOLD_US = 200;
	localparam int INIT_WAIT_US = 500;
	localparam int MODE_LOAD_GAP_NS = 15;
	localparam int ACT_TO_PRE_MIN_NS = 36;
	localparam int ACT_TO_ACCESS_NS = 15;
	localparam int PRECHARGE_PERIOD_NS = 15;
	localparam int REFRESH_INTERVAL_MAX_NS = 7800;
	localparam int REFRESH_CYCLE_NS = 110;
	localparam int WRITE_RECOVERY_NS = 15;
	// write to read delay in tenths of a memory clock
	localparam int WRITE_TO_READ_X10 = 40;
	localparam int RESET_HOLD_CYC_DEF =
		(RESET_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_CYC_DEF =
		(INIT_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MRD_CYC =
		(MODE_LOAD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAS_CYC =
		(ACT_TO_PRE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RCD_CYC =
		(ACT_TO_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RP_CYC =
		(PRECHARGE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RFC_CYC =
		(REFRESH_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_CYC =
		(WRITE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// a longest time rounds down
	localparam int REFI_CYC = REFRESH_INTERVAL_MAX_NS / CLK_PERIOD_NS;
	localparam int WTR_MCK = (WRITE_TO_READ_X10 + 9) / 10;
	localparam int REF_GUARD_CYC = 64;
	localparam int BURST_MCK = 4;
	localparam int NUM_BANKS = 8;
	localparam logic [3:0] RL_MIN = 4'h5;
	localparam logic [3:0] RL_MAX = 4'hA;
	localparam logic [3:0] WL_MIN = 4'h5;
	localparam logic [3:0] WL_MAX = 4'h8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_REFCNT = 8'h08;
	localparam int CTRL_USER_REF_BIT = 0;
	localparam int CTRL_RL_LSB = 4;
	localparam int CTRL_WL_LSB = 8;
	localparam logic CTRL_USER_REF_RST = 1'b0;
	localparam logic [3:0] CTRL_RL_RST = 4'h5;
	localparam logic [3:0] CTRL_WL_RST = 4'h5;
	typedef enum logic [2:0] {
		C_NOP = 3'b000,
		C_MRS = 3'b001,
		C_ACT = 3'b010,
		C_PRE = 3'b011,
		C_REF = 3'b100,
		C_RD  = 3'b101,
		C_WR  = 3'b110
	} ddrte_cmd_t;
	typedef enum logic [1:0] {
		S_RESET = 2'b00,
		S_INIT  = 2'b01,
		S_RUN   = 2'b10
	} ddrte_state_t;
endpackage

/* rtl/ddrte_bank_timer.sv */
// per-bank activate, precharge and write recovery timers
`timescale 1ns/10ps
module ddrte_bank_timer
	import ddrte_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       mck_rise,
	input  wire logic       act,
	input  wire logic       pre,
	input  wire logic       rd,
	input  wire logic       wr,
	input  wire logic [3:0] wl,
	output logic            act_ok,
	output logic            pre_ok,
	output logic            rw_ok,
	output logic            rd_ok,
	output logic            quiet
);
	logic [7:0] ras_cnt;
	logic [7:0] rcd_cnt;
	logic [7:0] rp_cnt;
	logic [7:0] wr_cnt;
	logic [3:0] wtr_cnt;
	logic [4:0] wend_cnt;
	logic [7:0] s_act;
	logic [7:0] s_pre;
	logic [7:0] s_wend;
	logic [3:0] m_wend;
	wire        wend = mck_rise && wend_cnt == 5'h01;

	always_ff @(posedge clk) begin
		if (rst) begin
			ras_cnt <= 8'h00;
			rcd_cnt <= 8'h00;
			rp_cnt <= 8'h00;
			wr_cnt <= 8'h00;
			wtr_cnt <= 4'h0;
			wend_cnt <= 5'h00;
		end else begin
			ras_cnt <= act ? 8'(RAS_CYC - 1) : ras_cnt - {7'h00, ras_cnt != 0}; // [R4]
			rcd_cnt <= act ? 8'(RCD_CYC - 1) : rcd_cnt - {7'h00, rcd_cnt != 0}; // [R5]
			rp_cnt <= pre ? 8'(RP_CYC - 1) : rp_cnt - {7'h00, rp_cnt != 0}; // [R6]
			// write ends after latency plus burst, in memory clocks
			wend_cnt <= wr ? 5'({1'b0, wl} + 5'(BURST_MCK)) :
				wend_cnt - {4'h0, mck_rise && wend_cnt != 0};
			wr_cnt <= wend ? 8'(WR_CYC - 1) : wr_cnt - {7'h00, wr_cnt != 0}; // [R9]
			wtr_cnt <= wend ? 4'(WTR_MCK) :
				wtr_cnt - {3'h0, mck_rise && wtr_cnt != 0}; // [R10] [R11]
		end
	end

	assign act_ok = rp_cnt == 8'h00; // [R6]
	assign rw_ok = rcd_cnt == 8'h00 && rp_cnt == 8'h00; // [R5] [R6]
	assign rd_ok = rw_ok && wend_cnt == 5'h00 && wtr_cnt == 4'h0; // [R10]
	assign pre_ok = ras_cnt == 8'h00 && wend_cnt == 5'h00 && wr_cnt == 8'h00; // [R4] [R9]
	assign quiet = act_ok && wend_cnt == 5'h00 && wr_cnt == 8'h00; // [R15]

	// helpers for the checks below only
	always_ff @(posedge clk) begin
		if (rst) begin
			s_act <= 8'hFF;
			s_pre <= 8'hFF;
			s_wend <= 8'hFF;
			m_wend <= 4'hF;
		end else begin
			s_act <= act ? 8'h01 : s_act + {7'h00, s_act != 8'hFF};
			s_pre <= pre ? 8'h01 : s_pre + {7'h00, s_pre != 8'hFF};
			s_wend <= wend ? 8'h01 : s_wend + {7'h00, s_wend != 8'hFF};
			m_wend <= wend ? 4'h0 :
				m_wend + {3'h0, mck_rise && m_wend != 4'hF};
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	a_act_to_pre: // [R4]
		assert property (pre |-> int'(s_act) >= RAS_CYC)
		else $error("precharge too soon after activate");
	a_act_to_access: // [R5]
		assert property ((rd || wr) |-> int'(s_act) >= RCD_CYC)
		else $error("access too soon after activate");
	a_pre_period: // [R6]
		assert property ((act || rd || wr) |-> int'(s_pre) >= RP_CYC)
		else $error("bank used during precharge period");
	a_write_recovery: // [R9]
		assert property (pre |-> wend_cnt == 5'h00 && int'(s_wend) >= WR_CYC)
		else $error("precharge inside write recovery");
	a_write_to_read: // [R10]
		assert property (rd |-> wend_cnt == 5'h00 && int'(m_wend) >= WTR_MCK)
		else $error("read too soon after write");
endmodule

/* rtl/ddrte_enforcer.sv */
// ddr3 command timing enforcer between scheduler and memory
// Summary of operation
// R1: hold memory reset for the reset-hold time before the first mode load.
// R2: after reset release, send nothing until the init wait has passed.
// R3: after a mode register load, wait the mode load gap for any command.
// R4: no precharge of a bank before activate-to-precharge minimum has passed.
// R5: no read or write to a bank before activate-to-access delay elapses.
// R6: no access to a bank before its precharge period has elapsed.
// R7: refresh on its own within the max interval unless user refresh is on; a bank still busy REF_GUARD_CYC cycles after it falls due delays it past.
// R8: after auto-refresh, no command at all until refresh cycle time passes.
// R9: after a write ends, wait write recovery time before precharging a bank.
// R10: after a write ends, wait write-to-read delay before reading that bank.
// R11: write-to-read delay held in whole memory clocks, fractions rounded up.
// R12: read data expected a set read latency, five to ten memory clocks.
// R13: write data presented a set write latency, five to eight memory clocks.
// R14: minimum times converted to clock counts with the clock period, rounding up.
// R15: each bank has its own timers, so banks delay each other only while a due refresh waits for all banks to be quiet.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/10ps
module ddrte_enforcer
	import ddrte_pkg::*;
#(
	parameter int RESET_HOLD_CYC = RESET_HOLD_CYC_DEF,
	parameter int INIT_CYC       = INIT_CYC_DEF
)(
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic        MCK,
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	input  wire logic        CMD_VALID,
	input  wire logic [2:0]  CMD_CODE,
	input  wire logic [2:0]  CMD_BANK,
	output logic             CMD_READY,
	output logic             MEM_RESET_N,
	output logic             MEM_CMD_VALID,
	output logic      [2:0]  MEM_CMD,
	output logic      [2:0]  MEM_BANK,
	output logic             RD_DATA_DUE,
	output logic             WR_DATA_DUE,
	output logic             INIT_DONE
);
	ddrte_state_t           state;
	ddrte_state_t           next_state;
	logic [23:0]            phase_cnt;
	logic [7:0]             gap_cnt;
	logic [15:0]            ref_age;
	logic [15:0]            ref_cnt;
	logic                   user_ref;
	logic [3:0]             rl;
	logic [3:0]             wl;
	logic                   mck_s1;
	logic                   mck_s2;
	logic                   mck_s3;
	logic                   mck_lvl;
	logic [15:0]            rd_pipe;
	logic [15:0]            wr_pipe;
	logic                   rd_pend;
	logic                   wr_pend;
	logic [NUM_BANKS-1:0]   act_ok;
	logic [NUM_BANKS-1:0]   pre_ok;
	logic [NUM_BANKS-1:0]   rw_ok;
	logic [NUM_BANKS-1:0]   rd_ok;
	logic [NUM_BANKS-1:0]   quiet;
	logic [31:0]            rd_mux;

	// memory clock sampled; an edge counts once stages two and three agree
	wire mck_agree = mck_s2 == mck_s3;
	wire mck_rise = mck_agree && mck_s3 && !mck_lvl; // [R12] [R13]

	always_ff @(posedge CLK) begin
		if (RST) begin
			mck_s1 <= 1'b0;
			mck_s2 <= 1'b0;
			mck_s3 <= 1'b0;
			mck_lvl <= 1'b0;
		end else begin
			mck_s1 <= MCK;
			mck_s2 <= mck_s1;
			mck_s3 <= mck_s2;
			mck_lvl <= mck_agree ? mck_s3 : mck_lvl;
		end
	end

	// power-up sequencing
	wire hold_done = int'(phase_cnt) + 1 >= RESET_HOLD_CYC; // [R1]
	wire init_done = int'(phase_cnt) + 1 >= INIT_CYC; // [R2]

	always_comb begin
		next_state = state;
		case (state)
			S_RESET: begin
				if (hold_done)
					next_state = S_INIT;
			end
			S_INIT: begin
				if (init_done)
					next_state = S_RUN;
			end
			S_RUN: next_state = S_RUN;
			default: next_state = S_RESET;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			state <= S_RESET;
			phase_cnt <= 24'h000000;
			MEM_RESET_N <= 1'b0;
			INIT_DONE <= 1'b0;
		end else begin
			state <= next_state;
			phase_cnt <= (next_state != state) ? 24'h000000 :
				phase_cnt + {23'h000000, phase_cnt != 24'hFFFFFF};
			MEM_RESET_N <= state != S_RESET; // [R1]
			INIT_DONE <= state == S_RUN;
		end
	end

	// command gating
	wire       glob_ok = state == S_RUN && gap_cnt == 8'h00; // [R2] [R3] [R8]
	wire       all_quiet = &quiet;
	// raised early so a bank stalled under REF_GUARD_CYC cycles cannot push the gap past the maximum
	wire       ref_due = !user_ref &&
		int'(ref_age) >= REFI_CYC - REF_GUARD_CYC; // [R7]
	wire       auto_ref = ref_due && glob_ok && all_quiet; // [R7]
	wire       is_mrs = CMD_CODE == C_MRS;
	wire       is_act = CMD_CODE == C_ACT;
	wire       is_pre = CMD_CODE == C_PRE;
	wire       is_ref = CMD_CODE == C_REF;
	wire       is_rd = CMD_CODE == C_RD;
	wire       is_wr = CMD_CODE == C_WR;
	wire       is_nop = CMD_CODE == C_NOP;
	wire       cmd_ok = is_mrs || is_nop ||
		(is_act && act_ok[CMD_BANK]) || // [R6]
		(is_pre && pre_ok[CMD_BANK]) || // [R4] [R9]
		(is_ref && all_quiet) ||
		(is_rd && rd_ok[CMD_BANK]) || // [R5] [R10]
		(is_wr && rw_ok[CMD_BANK]); // [R5]
	assign CMD_READY = glob_ok && !ref_due && cmd_ok;
	wire       issue_user = CMD_VALID && CMD_READY && !is_nop;
	wire       issue = auto_ref || issue_user;
	wire [2:0] next_cmd = auto_ref ? C_REF : CMD_CODE;
	wire [2:0] next_bank = auto_ref ? 3'h0 : CMD_BANK;
	wire       iss_mrs = issue && next_cmd == C_MRS;
	wire       iss_ref = issue && next_cmd == C_REF;
	wire       iss_rd = issue && next_cmd == C_RD;
	wire       iss_wr = issue && next_cmd == C_WR;

	always_ff @(posedge CLK) begin
		if (RST) begin
			MEM_CMD_VALID <= 1'b0;
			MEM_CMD <= C_NOP;
			MEM_BANK <= 3'h0;
			gap_cnt <= 8'h00;
			ref_age <= 16'h0000;
			ref_cnt <= 16'h0000;
		end else begin
			MEM_CMD_VALID <= issue;
			MEM_CMD <= issue ? next_cmd : C_NOP;
			MEM_BANK <= issue ? next_bank : 3'h0;
			if (iss_mrs)
				gap_cnt <= 8'(MRD_CYC - 1); // [R3] [R14]
			else if (iss_ref)
				gap_cnt <= 8'(RFC_CYC - 1); // [R8] [R14]
			else
				gap_cnt <= gap_cnt - {7'h00, gap_cnt != 8'h00};
			if (iss_ref || state != S_RUN)
				ref_age <= 16'h0000; // [R7]
			else
				ref_age <= ref_age + {15'h0000, ref_age != 16'hFFFF};
			ref_cnt <= ref_cnt + {15'h0000, iss_ref};
		end
	end

	// one timer set per bank
	for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
		wire hit = issue && next_bank == 3'(b);
		ddrte_bank_timer u_timer (
			.clk      (CLK),
			.rst      (RST),
			.mck_rise (mck_rise),
			.act      (hit && next_cmd == C_ACT),
			.pre      (hit && next_cmd == C_PRE),
			.rd       (hit && next_cmd == C_RD),
			.wr       (hit && next_cmd == C_WR),
			.wl       (wl),
			.act_ok   (act_ok[b]),
			.pre_ok   (pre_ok[b]),
			.rw_ok    (rw_ok[b]),
			.rd_ok    (rd_ok[b]),
			.quiet    (quiet[b])
		); // [R15]
	end

	// latency pipes step on memory clock edges
	always_ff @(posedge CLK) begin
		if (RST) begin
			rd_pipe <= 16'h0000;
			wr_pipe <= 16'h0000;
			rd_pend <= 1'b0;
			wr_pend <= 1'b0;
			RD_DATA_DUE <= 1'b0;
			WR_DATA_DUE <= 1'b0;
		end else begin
			rd_pend <= !mck_rise && (rd_pend || iss_rd);
			wr_pend <= !mck_rise && (wr_pend || iss_wr);
			if (mck_rise) begin
				rd_pipe <= {rd_pipe[14:0], rd_pend || iss_rd};
				wr_pipe <= {wr_pipe[14:0], wr_pend || iss_wr};
			end
			RD_DATA_DUE <= mck_rise && rd_pipe[rl - 4'h1]; // [R12]
			WR_DATA_DUE <= mck_rise && wr_pipe[wl - 4'h1]; // [R13]
		end
	end

	// register port
	wire [3:0] wd_rl = WDATA[CTRL_RL_LSB +: 4];
	wire [3:0] wd_wl = WDATA[CTRL_WL_LSB +: 4];
	wire [3:0] next_rl = wd_rl < RL_MIN ? RL_MIN :
		(wd_rl > RL_MAX ? RL_MAX : wd_rl); // [R12]
	wire [3:0] next_wl = wd_wl < WL_MIN ? WL_MIN :
		(wd_wl > WL_MAX ? WL_MAX : wd_wl); // [R13]
	wire       wr_ctrl = WR && ADDR == REG_CTRL;
	wire [31:0] ctrl_val = {20'h00000, wl, rl, 3'h0, user_ref};
	wire [31:0] stat_val = {16'h0000, quiet, 3'h0, ref_due,
		gap_cnt != 8'h00, 1'b0, state};

	always_comb begin
		case (ADDR)
			REG_CTRL: rd_mux = ctrl_val;
			REG_STATUS: rd_mux = stat_val;
			REG_REFCNT: rd_mux = {16'h0000, ref_cnt};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			user_ref <= CTRL_USER_REF_RST;
			rl <= CTRL_RL_RST;
			wl <= CTRL_WL_RST;
			RDATA <= 32'h00000000;
		end else begin
			if (wr_ctrl) begin
				user_ref <= WDATA[CTRL_USER_REF_BIT]; // [R7]
				rl <= next_rl;
				wl <= next_wl;
			end
			RDATA <= RD ? rd_mux : 32'h00000000;
		end
	end

	// helpers for the checks below only
	logic [23:0] rst_low;
	logic [23:0] since_rel;
	logic [7:0]  since_cmd;
	logic [2:0]  last_cmd;
	logic [15:0] ref_gap;

	always_ff @(posedge CLK) begin
		if (RST) begin
			rst_low <= 24'h000000;
			since_rel <= 24'h000000;
			since_cmd <= 8'hFF;
			last_cmd <= C_NOP;
			ref_gap <= 16'h0000;
		end else begin
			rst_low <= MEM_RESET_N ? 24'h000000 :
				rst_low + {23'h000000, rst_low != 24'hFFFFFF};
			since_rel <= !MEM_RESET_N ? 24'h000000 :
				since_rel + {23'h000000, since_rel != 24'hFFFFFF};
			since_cmd <= MEM_CMD_VALID ? 8'h01 :
				since_cmd + {7'h00, since_cmd != 8'hFF};
			last_cmd <= MEM_CMD_VALID ? MEM_CMD : last_cmd;
			ref_gap <= (!INIT_DONE || (MEM_CMD_VALID && MEM_CMD == C_REF)) ?
				16'h0000 : ref_gap + {15'h0000, ref_gap != 16'hFFFF};
		end
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (RST);

	sequence s_cmd_after_mrs;
		MEM_CMD_VALID && last_cmd == C_MRS;
	endsequence
	sequence s_cmd_after_ref;
		MEM_CMD_VALID && last_cmd == C_REF;
	endsequence

	a_reset_hold_time: // [R1]
		assert property ($rose(MEM_RESET_N) |-> int'(rst_low) >= RESET_HOLD_CYC)
		else $error("memory reset released too early");
	a_init_quiet_cmds: // [R2]
		assert property (MEM_CMD_VALID |-> int'(since_rel) >= INIT_CYC)
		else $error("command inside init wait");
	a_init_quiet_start: // [R2]
		assert property ($rose(MEM_RESET_N) |-> !MEM_CMD_VALID [*8])
		else $error("command right after reset release");
	a_mode_load_gap: // [R3]
		assert property (s_cmd_after_mrs |-> int'(since_cmd) >= MRD_CYC)
		else $error("command inside mode load gap");
	a_refresh_cycle_gap: // [R8]
		assert property (s_cmd_after_ref |-> int'(since_cmd) >= RFC_CYC)
		else $error("command inside refresh cycle time");
	a_refresh_interval: // [R7]
		assert property (!user_ref |-> int'(ref_gap) <= REFI_CYC)
		else $error("refresh interval exceeded");
	a_auto_ref_issue: // [R7]
		assert property (auto_ref |=> MEM_CMD_VALID && MEM_CMD == C_REF)
		else $error("due refresh not issued");
	a_ready_gated: // [R3] [R8]
		assert property (gap_cnt != 8'h00 |-> !CMD_READY && !issue)
		else $error("command accepted inside global gap");
	a_read_latency: // [R12]
		assert property (RD_DATA_DUE |-> $past(rd_pipe[rl - 4'h1]))
		else $error("read data due without pending read");
	a_write_latency: // [R13]
		assert property (WR_DATA_DUE |-> $past(wr_pipe[wl - 4'h1]))
		else $error("write data due without pending write");
endmodule

/* sim/ddrte_mem_model.sv */
// memory device model: free memory clock and command spacing checks
`timescale 1ns/10ps
module ddrte_mem_model
	import ddrte_pkg::*;
#(
	parameter int MCK_HALF_NS = 80
)(
	input  wire logic       clk,
	output logic            mck,
	input  wire logic       reset_n,
	input  wire logic       init_done,
	input  wire logic       cmd_valid,
	input  wire logic [2:0] cmd,
	input  wire logic [2:0] bank,
	output int              viol
);
	int now;
	int t_mrs;
	int t_ref;
	int t_act [NUM_BANKS];
	int t_pre [NUM_BANKS];

	// odd start offset keeps memory edges apart from system edges
	initial begin
		mck = 1'b0;
		#37;
		forever #(MCK_HALF_NS) mck = ~mck;
	end

	task automatic flag(input bit bad, input string m);
		if (bad) begin
			viol++;
			$display("CHECK FAILED t=%0t memory saw %s", $time, m);
		end
	endtask

	// one process owns every stamp, so nothing has two drivers
	initial begin
		viol = 0;
		now = 0;
		t_mrs = -100000;
		t_ref = -100000;
		foreach (t_act[i]) begin
			t_act[i] = -100000;
			t_pre[i] = -100000;
		end
		forever begin
			@(posedge clk);
			now++;
			if (cmd_valid === 1'b1) begin
				flag(reset_n !== 1'b1 || init_done !== 1'b1,
					"early cmd");
				flag(now - t_mrs < MRD_CYC, "mode load gap");
				flag(now - t_ref < RFC_CYC, "refresh gap");
				case (cmd)
					C_MRS: t_mrs = now;
					C_REF: t_ref = now;
					C_ACT: begin
						flag(now - t_pre[bank] < RP_CYC,
							"precharge period");
						t_act[bank] = now;
					end
					C_PRE: begin
						flag(now - t_act[bank] < RAS_CYC,
							"act to pre");
						t_pre[bank] = now;
					end
					default: begin
						flag(now - t_act[bank] < RCD_CYC,
							"act to access");
						flag(now - t_pre[bank] < RP_CYC,
							"access closed");
					end
				endcase
			end
		end
	end
endmodule

/* sim/tb_ddrte_enforcer.sv */
// self-checking bench for the ddr3 command timing enforcer
`timescale 1ns/10ps
module tb_ddrte_enforcer
	import ddrte_pkg::*;
;
	localparam int HOLD = 20;
	localparam int INIT = 30;
	localparam int MCKC = 16;
	logic        clk;
	logic        rst;
	logic        wr;
	logic        rd;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        cmd_valid;
	logic [2:0]  cmd_code;
	logic [2:0]  cmd_bank;
	logic [31:0] rdata;
	logic        cmd_ready;
	logic        mem_reset_n;
	logic        mem_cmd_valid;
	logic [2:0]  mem_cmd;
	logic [2:0]  mem_bank;
	logic        rd_due;
	logic        wr_due;
	logic        init_done;
	logic        mck;
	logic [3:0]  rl;
	logic [3:0]  wl;
	int          viol;
	int          fail_count = 0;
	int          checks = 0;
	int          nref = 0;
	int          tref;
	int          n;
	int          ta;
	int          tc;
	int          tw;

	ddrte_enforcer #(.RESET_HOLD_CYC(HOLD), .INIT_CYC(INIT)) u_ddrte_enforcer (
		.CLK(clk), .RST(rst), .MCK(mck), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .CMD_VALID(cmd_valid),
		.CMD_CODE(cmd_code), .CMD_BANK(cmd_bank), .CMD_READY(cmd_ready),
		.MEM_RESET_N(mem_reset_n), .MEM_CMD_VALID(mem_cmd_valid),
		.MEM_CMD(mem_cmd), .MEM_BANK(mem_bank), .RD_DATA_DUE(rd_due),
		.WR_DATA_DUE(wr_due), .INIT_DONE(init_done));

	ddrte_mem_model u_ddrte_mem_model (
		.clk(clk), .mck(mck), .reset_n(mem_reset_n), .init_done(init_done),
		.cmd_valid(mem_cmd_valid), .cmd(mem_cmd), .bank(mem_bank),
		.viol(viol));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask

	task automatic report_and_stop();
		chk(viol === 0, "memory model saw spacing faults");
		$display("checks=%0d failures=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rreg(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] msk, input string m);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk((rdata & msk) === e, m);
		@(posedge clk);
	endtask

	// waits are bounded; a stuck ready ends the run
	task automatic send(input logic [2:0] c, input logic [2:0] b,
		output int t);
		int k;
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_bank <= b;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (cmd_ready !== 1'b1 && k < 3000);
		if (k >= 3000) begin
			chk(1'b0, "command never taken");
			report_and_stop();
		end
		@(posedge clk);
		t = int'($time / 10);
		cmd_valid <= 1'b0;
		@(negedge clk);
		// a scheduler refresh carries its own bank field through
		chk(mem_cmd_valid === (c != 3'h0) && mem_cmd === c && mem_bank ===
			((c == C_NOP) ? 3'h0 : b), "command echo");
		@(posedge clk);
	endtask

	task automatic due(input bit w, input int t0, input logic [3:0] lat);
		int k;
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while ((w ? wr_due : rd_due) !== 1'b1 && k < 400);
		if (k >= 400) begin
			chk(1'b0, "data due never seen");
			report_and_stop();
		end
		k = int'($time / 10) - t0;
		chk(k >= lat * MCKC && k <= lat * MCKC + 24, "data due spacing");
		// back on a rising edge so the next driver starts there
		@(posedge clk);
	endtask

	always @(posedge clk)
		if (mem_cmd_valid === 1'b1 && mem_cmd === C_REF) begin
			if (nref > 0)
				chk(int'($time / 10) - tref <= REFI_CYC, "late refresh");
			tref = int'($time / 10);
			nref++;
		end

	initial begin
		rst = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		cmd_valid = 1'b0;
		cmd_code = 3'h0;
		cmd_bank = 3'h0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (mem_reset_n !== 1'b1 && n < 100);
		chk(n >= HOLD && n <= HOLD + 3, "reset hold length");
		if (n >= 100)
			report_and_stop();
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (init_done !== 1'b1 && n < 100);
		chk(n >= INIT && n <= INIT + 3, "init wait length");
		if (n >= 100)
			report_and_stop();
		@(posedge clk);
		$display("test reset and init done");
		rreg(REG_CTRL, 32'h00000550, 32'hFFFFFFFF, "ctrl reset value");
		rreg(REG_STATUS, 32'h00000002, 32'h00000003, "run state");
		wreg(8'h0C, 32'hFFFFFFFF);
		rreg(8'h0C, 32'h0, 32'hFFFFFFFF, "unmapped read");
		wreg(REG_CTRL, 32'h00000FF0);
		rreg(REG_CTRL, 32'h000008A0, 32'hFFFFFFFF, "clamp high");
		wreg(REG_CTRL, 32'h00000010);
		rreg(REG_CTRL, 32'h00000550, 32'hFFFFFFFF, "clamp low");
		wreg(REG_CTRL, 32'h00000670);
		rl = 4'h7;
		wl = 4'h6;
		$display("test registers done");
		send(C_NOP, 3'h0, ta);
		send(C_MRS, 3'h0, ta);
		send(C_ACT, 3'h1, tc);
		chk(tc - ta >= MRD_CYC, "mode load gap");
		send(C_ACT, 3'h2, ta);
		send(C_RD, 3'h2, tc);
		chk(tc - ta >= RCD_CYC, "act to read");
		due(1'b0, tc, rl);
		send(C_WR, 3'h1, tw);
		send(C_RD, 3'h2, tc);
		chk(tc - tw <= 4, "other bank held by write");
		due(1'b1, tw, wl);
		// precharge first, so only write recovery can hold it back
		send(C_PRE, 3'h1, ta);
		chk(ta - tw >= (wl + 3) * MCKC + WR_CYC, "write recovery");
		send(C_RD, 3'h1, tc);
		chk(tc - tw >= (wl + 3 + WTR_MCK) * MCKC, "write to read");
		send(C_PRE, 3'h2, ta);
		send(C_ACT, 3'h2, tc);
		chk(tc - ta >= RP_CYC, "precharge period");
		send(C_PRE, 3'h2, ta);
		chk(ta - tc >= RAS_CYC, "act to pre");
		send(C_REF, 3'h5, ta);
		send(C_ACT, 3'h3, tc);
		chk(tc - ta >= RFC_CYC, "refresh cycle");
		send(C_PRE, 3'h3, ta);
		$display("test command spacing done");
		n = nref;
		ta = 0;
		while (nref < n + 2 && ta < 2 * REFI_CYC + 100) begin
			@(posedge clk);
			ta++;
		end
		chk(nref >= n + 2, "auto refresh count");
		if (nref < n + 2)
			report_and_stop();
		repeat (4) @(posedge clk);
		rreg(REG_REFCNT, nref, 32'h0000FFFF, "refresh counter");
		wreg(REG_CTRL, 32'h00000671);
		n = nref;
		repeat (REFI_CYC + 100) @(posedge clk);
		chk(nref === n, "user refresh mode");
		$display("test refresh done");
		report_and_stop();
	end
endmodule
